// [shared/wpt_params.svh]
`ifndef WPT_PARAMS_SVH
`define WPT_PARAMS_SVH
// Range source select codes
`define WPT_RSRC_IP 2'h0
`define WPT_RSRC_DATA 2'h1
`define WPT_RSRC_RADDR 2'h2
`define WPT_RSRC_WADDR 2'h3
// Equal source select codes
`define WPT_ESRC_IP 2'h0
`define WPT_ESRC_DATA 2'h1
`define WPT_ESRC_WADDR 2'h2
`define WPT_ESRC_TASK 2'h3
// Data and address width default
`define WPT_WIDTH 16
// Shadow memory address width default
`define WPT_SHADOW_AW 8
`endif

// [shared/wpt_pkg.sv]
package wpt_pkg;
    typedef enum logic [1:0] {
        WPT_RNG_OFF = 2'h0,
        WPT_RNG_IN = 2'h1,
        WPT_RNG_OUT = 2'h3
    } wpt_rng_mode_t;
    typedef enum logic [2:0] {
        WPT_EQ_OFF = 3'h0,
        WPT_EQ_V0 = 3'h1,
        WPT_EQ_V01 = 3'h2,
        WPT_EQ_V012 = 3'h3,
        WPT_EQ_MASK1 = 3'h4,
        WPT_EQ_MASK12 = 3'h5,
        WPT_EQ_V0_OR_IN = 3'h6,
        WPT_EQ_IN = 3'h7
    } wpt_eq_mode_t;
    typedef struct packed {
        logic [1:0] rng_src;
        wpt_rng_mode_t rng_mode;
        logic [1:0] eq_src;
        wpt_eq_mode_t eq_mode;
        logic eq_out_mode;
        logic use_and;
        logic debug_en;
        logic brk_out_en;
    } wpt_cfg_t;
    typedef enum logic [1:0] {
        WPT_RUN = 2'h0,
        WPT_HALT = 2'h1,
        WPT_STEP = 2'h3
    } wpt_state_t;
endpackage

// [design/wpt_watchpoint.sv]
`timescale 1ns/100ps
`include "wpt_params.svh"
module wpt_watchpoint
    import wpt_pkg::*;
#(
    parameter int WIDTH = `WPT_WIDTH,
    parameter int SHADOW_AW = `WPT_SHADOW_AW
) (
    input wire logic i_clock, // 10 MHz core clock
    input wire logic i_reset, // Async reset, high
    input wire logic i_enable, // Clock enable
    input wire wpt_cfg_t i_cfg, // Watchpoint configuration
    input wire logic [WIDTH-1:0] i_range_lower_bound, // Range low bound
    input wire logic [WIDTH-1:0] i_range_upper_bound, // Range high bound
    input wire logic [WIDTH-1:0] i_match_value_first, // Value 0 or mask
    input wire logic [WIDTH-1:0] i_match_value_second, // Value 1
    input wire logic [WIDTH-1:0] i_match_value_third, // Value 2
    input wire logic i_fetch, // Instruction fetch strobe
    input wire logic [WIDTH-1:0] i_ip, // Instruction pointer
    input wire logic i_rd, // Data read strobe
    input wire logic i_wr, // Data write strobe
    input wire logic [WIDTH-1:0] i_addr, // Data address
    input wire logic [WIDTH-1:0] i_data, // Data value
    input wire logic [WIDTH-1:0] i_task_id, // OS task identifier
    input wire logic i_resume, // Debugger resumes
    input wire logic i_step, // Debugger single step
    input wire logic i_suspend_periph_en, // Suspend peripherals option
    input wire logic [3:0] i_monitor_level, // Monitor interrupt level
    input wire logic [3:0] i_irq_level, // Pending interrupt level
    input wire logic i_irq_req, // Interrupt pending
    input wire logic i_step_int_mask_en, // Mask interrupts on step
    input wire logic [SHADOW_AW-1:0] i_shadow_raddr, // Debugger shadow read
    output logic o_halt, // Core halted
    output logic o_break_pulse, // One-cycle break request
    output logic o_trigger_out, // Trigger output pulse
    output logic o_irq_allow, // Interrupt service allowed
    output logic o_periph_suspend, // Peripherals suspended
    output logic [WIDTH-1:0] o_shadow_rdata // Shadow read data
);
    // ****************************************
    // Comparators
    // ****************************************
    logic [WIDTH-1:0] rng_in;
    logic [WIDTH-1:0] eq_in;
    logic rng_hit;
    logic eq_hit;
    logic hit;
    logic qualify;
    logic [WIDTH-1:0] mask;
    logic eq2_hit;

    assign qualify = i_fetch | i_rd | i_wr;
    assign mask = i_match_value_first;
    // Third is lower, second is upper bound in the second range
    assign eq2_hit = (eq_in > i_match_value_third) && (eq_in < i_match_value_second);

    always_comb begin
        unique case (i_cfg.rng_src)
            `WPT_RSRC_IP: rng_in = i_ip;
            `WPT_RSRC_DATA: rng_in = i_data;
            `WPT_RSRC_RADDR: rng_in = i_addr;
            `WPT_RSRC_WADDR: rng_in = i_addr;
        endcase
        unique case (i_cfg.eq_src)
            `WPT_ESRC_IP: eq_in = i_ip;
            `WPT_ESRC_DATA: eq_in = i_data;
            `WPT_ESRC_WADDR: eq_in = i_addr;
            `WPT_ESRC_TASK: eq_in = i_task_id;
        endcase
        case (i_cfg.rng_mode)
            WPT_RNG_IN: rng_hit = (rng_in > i_range_lower_bound) &&
                (rng_in < i_range_upper_bound);
            WPT_RNG_OUT: rng_hit = (rng_in < i_range_lower_bound) ||
                (rng_in > i_range_upper_bound);
            default: rng_hit = 1'b0;
        endcase
        // Address sources only count on the matching access kind
        if (i_cfg.rng_src == `WPT_RSRC_RADDR && !i_rd) begin
            rng_hit = 1'b0;
        end
        if (i_cfg.rng_src == `WPT_RSRC_WADDR && !i_wr) begin
            rng_hit = 1'b0;
        end
        unique case (i_cfg.eq_mode)
            WPT_EQ_OFF: eq_hit = 1'b0;
            WPT_EQ_V0: eq_hit = (eq_in == i_match_value_first);
            WPT_EQ_V01: eq_hit = (eq_in == i_match_value_first) ||
                (eq_in == i_match_value_second);
            WPT_EQ_V012: eq_hit = (eq_in == i_match_value_first) ||
                (eq_in == i_match_value_second) || (eq_in == i_match_value_third);
            WPT_EQ_MASK1: eq_hit = ((eq_in & ~mask) ==
                (i_match_value_second & ~mask));
            WPT_EQ_MASK12: eq_hit = ((eq_in & ~mask) == (i_match_value_second & ~mask)) ||
                ((eq_in & ~mask) == (i_match_value_third & ~mask));
            WPT_EQ_V0_OR_IN: eq_hit = (eq_in == i_match_value_first) || eq2_hit;
            WPT_EQ_IN: eq_hit = eq2_hit;
        endcase
        // Outside variant of the second range comparator
        if (i_cfg.eq_out_mode && i_cfg.eq_mode == WPT_EQ_IN) begin
            eq_hit = (eq_in < i_match_value_third) || (eq_in > i_match_value_second);
        end
        if (i_cfg.eq_src == `WPT_ESRC_WADDR && !i_wr) begin
            eq_hit = 1'b0;
        end
        hit = qualify && (i_cfg.use_and ? (rng_hit && eq_hit) : (rng_hit || eq_hit));
    end

    // ****************************************
    // Run control
    // ****************************************
    wpt_state_t state_ff;
    wpt_state_t nxt_state;
    logic halt_ff;
    logic nxt_halt;
    logic brk_ff;
    logic nxt_brk;
    logic trig_ff;
    logic nxt_trig;
    logic irq_ff;
    logic nxt_irq;
    logic susp_ff;
    logic nxt_susp;

    always_comb begin
        nxt_state = state_ff;
        nxt_brk = 1'b0;
        nxt_trig = 1'b0;
        unique case (state_ff)
            WPT_RUN: begin
                if (hit) begin
                    nxt_brk = i_cfg.debug_en;
                    nxt_trig = i_cfg.brk_out_en;
                    if (i_cfg.debug_en) begin
                        nxt_state = WPT_HALT;
                    end
                end
            end
            WPT_HALT: begin
                if (i_step) begin
                    nxt_state = WPT_STEP;
                end else if (i_resume) begin
                    nxt_state = WPT_RUN;
                end
            end
            WPT_STEP: begin
                if (i_fetch) begin
                    nxt_state = WPT_HALT;
                end
            end
        endcase
        nxt_halt = (nxt_state == WPT_HALT);
        nxt_susp = i_suspend_periph_en && (nxt_state == WPT_HALT);
        unique case (nxt_state)
            WPT_RUN: nxt_irq = 1'b1;
            WPT_HALT: nxt_irq = !i_suspend_periph_en && i_irq_req &&
                (i_irq_level > i_monitor_level);
            WPT_STEP: nxt_irq = !i_step_int_mask_en;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_ff <= WPT_RUN;
            halt_ff <= 1'b0;
            brk_ff <= 1'b0;
            trig_ff <= 1'b0;
            irq_ff <= 1'b1;
            susp_ff <= 1'b0;
        end else if (i_enable) begin
            state_ff <= nxt_state;
            halt_ff <= nxt_halt;
            brk_ff <= nxt_brk;
            trig_ff <= nxt_trig;
            irq_ff <= nxt_irq;
            susp_ff <= nxt_susp;
        end
    end

    assign o_halt = halt_ff;
    assign o_break_pulse = brk_ff;
    assign o_trigger_out = trig_ff;
    assign o_irq_allow = irq_ff;
    assign o_periph_suspend = susp_ff;

    // ****************************************
    // Shadow memory
    // ****************************************
    // Array has no reset; debugger must not trust it before first write
    logic [WIDTH-1:0] shadow_mem [2**SHADOW_AW];
    logic [WIDTH-1:0] rdata_ff;
    logic [WIDTH-1:0] nxt_rdata;

    assign nxt_rdata = shadow_mem[i_shadow_raddr];

    always_ff @(posedge i_clock) begin
        if (i_enable && i_wr) begin
            shadow_mem[i_addr[SHADOW_AW-1:0]] <= i_data;
        end
    end

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            rdata_ff <= '0;
        end else if (i_enable) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_shadow_rdata = rdata_ff;

    // ****************************************
    // Checks
    // ****************************************
    chk_break_single: assert property (@(posedge i_clock) disable iff (i_reset)
        (o_break_pulse && i_enable) |=> !o_break_pulse)
        else $error("break pulse longer than one cycle");
    chk_break_halts: assert property (@(posedge i_clock) disable iff (i_reset)
        o_break_pulse |-> o_halt)
        else $error("break without halt");
    chk_hit_break: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_enable && state_ff == WPT_RUN && hit && i_cfg.debug_en) |=> o_break_pulse)
        else $error("hit did not break");
    chk_trig_cause: assert property (@(posedge i_clock) disable iff (i_reset)
        (o_trigger_out && $past(i_enable)) |-> $past(hit))
        else $error("trigger without hit");
    chk_step_mask: assert property (@(posedge i_clock) disable iff (i_reset)
        (state_ff == WPT_STEP && $past(i_step_int_mask_en) && $past(i_enable)) |-> !o_irq_allow)
        else $error("interrupt allowed in masked step");
    chk_susp_irq: assert property (@(posedge i_clock) disable iff (i_reset)
        o_periph_suspend |-> !o_irq_allow)
        else $error("interrupt while suspended");
    chk_in_range: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_cfg.rng_mode == WPT_RNG_IN && rng_in <= i_range_lower_bound) |-> !rng_hit)
        else $error("in-range hit at or below lower bound");
    chk_out_range: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_cfg.rng_mode == WPT_RNG_OUT && rng_hit) |->
        (rng_in < i_range_lower_bound || rng_in > i_range_upper_bound))
        else $error("out-range hit inside bounds");
endmodule

// [tb/wpt_pod.sv]
`timescale 1ns/100ps
// ****************
// Debugger pod
// ****************
module wpt_pod #(
    parameter int STRETCH = 4
) (
    input wire logic i_clock, // Core clock
    input wire logic i_rst_req, // Reset request from the bench
    output logic o_reset // Stretched target reset
);
    int cnt_ff;
    // Scaled down from milliseconds to keep the run short
    always_ff @(posedge i_clock or posedge i_rst_req) begin
        if (i_rst_req) begin
            cnt_ff <= STRETCH;
        end else if (cnt_ff > 0) begin
            cnt_ff <= cnt_ff - 1;
        end
    end
    assign o_reset = i_rst_req || (cnt_ff > 0);
endmodule

// [tb/watchpoint_trigger_logic_bench.sv]
`timescale 1ns/100ps
`include "wpt_params.svh"
module watchpoint_trigger_logic_bench;
    import wpt_pkg::*;
    logic i_clock = 0, rst_req = 1, i_reset;
    wpt_cfg_t cfg = '0;
    logic [15:0] lo = 0, hi = 0, v0 = 0, v1 = 0, v2 = 0, ip = 0, addr = 0, data = 0, tid = 0;
    logic fetch = 0, rd = 0, wr = 0, resume = 0, step = 0, susp = 0, smask = 0, irq_req = 0;
    logic en = 1;
    logic [3:0] mlev = 0, ilev = 0;
    logic [7:0] sraddr = 0;
    logic halt, brk, trig, irqa, psus;
    logic [15:0] srd, mem[8];
    logic [1:0] q[$];
    int errors = 0, checked = 0, cycles = 0;
    wpt_pod #(.STRETCH(4)) pod_u (.i_clock(i_clock), .i_rst_req(rst_req), .o_reset(i_reset));
    wpt_watchpoint dut_u (.i_clock(i_clock), .i_reset(i_reset), .i_enable(en), .i_cfg(cfg),
        .i_range_lower_bound(lo), .i_range_upper_bound(hi), .i_match_value_first(v0),
        .i_match_value_second(v1), .i_match_value_third(v2), .i_fetch(fetch), .i_ip(ip),
        .i_rd(rd), .i_wr(wr), .i_addr(addr), .i_data(data), .i_task_id(tid), .i_resume(resume),
        .i_step(step), .i_suspend_periph_en(susp), .i_monitor_level(mlev), .i_irq_level(ilev),
        .i_irq_req(irq_req), .i_step_int_mask_en(smask), .i_shadow_raddr(sraddr),
        .o_halt(halt), .o_break_pulse(brk), .o_trigger_out(trig), .o_irq_allow(irqa),
        .o_periph_suspend(psus), .o_shadow_rdata(srd));
    // ****************
    // Helpers
    // ****************
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        checked++;
        if (s !== e) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out();
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    function automatic logic inr(input logic [15:0] x, input logic [15:0] l, input logic [15:0] h);
        return x > l && x < h;
    endfunction
    function automatic logic exp_hit();
        logic [15:0] rx, ex;
        logic rr, er;
        rx = (cfg.rng_src == `WPT_RSRC_IP) ? ip : (cfg.rng_src == `WPT_RSRC_DATA) ? data : addr;
        rr = (cfg.rng_mode == WPT_RNG_IN) ? inr(rx, lo, hi) :
            (cfg.rng_mode == WPT_RNG_OUT) ? (rx < lo || rx > hi) : 1'b0;
        case (cfg.rng_src)
            `WPT_RSRC_RADDR: rr &= rd;
            `WPT_RSRC_WADDR: rr &= wr;
            default: ;
        endcase
        case (cfg.eq_src)
            `WPT_ESRC_IP: ex = ip;
            `WPT_ESRC_DATA: ex = data;
            `WPT_ESRC_WADDR: ex = addr;
            default: ex = tid;
        endcase
        case (cfg.eq_mode)
            WPT_EQ_V0: er = ex == v0;
            WPT_EQ_V01: er = ex == v0 || ex == v1;
            WPT_EQ_V012: er = ex == v0 || ex == v1 || ex == v2;
            WPT_EQ_MASK1: er = (ex & ~v0) == (v1 & ~v0);
            WPT_EQ_MASK12: er = (ex & ~v0) == (v1 & ~v0) || (ex & ~v0) == (v2 & ~v0);
            WPT_EQ_V0_OR_IN: er = ex == v0 || inr(ex, v2, v1);
            WPT_EQ_IN: er = cfg.eq_out_mode ? (ex < v2 || ex > v1) : inr(ex, v2, v1);
            default: er = 1'b0;
        endcase
        // Only a write address waits for its own strobe; other sources take any access
        if (cfg.eq_src == `WPT_ESRC_WADDR) begin
            er &= wr;
        end
        return (fetch | rd | wr) & (cfg.use_and ? (rr & er) : (rr | er));
    endfunction
    function automatic logic [15:0] r4();
        return 16'($urandom_range(0, 15));
    endfunction
    // ****************
    // Result watcher
    // ****************
    always @(posedge i_clock) begin
        #20;
        if (q.size() > 0) begin
            check({halt, trig}, q.pop_front());
        end
    end
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        forever #50 i_clock = ~i_clock;
    end
    // ****************
    // Stimulus
    // ****************
    initial begin
        void'($urandom(97));
        repeat (6) @(negedge i_clock);
        check({halt, irqa}, 2'h1);
        rst_req = 0;
        repeat (6) @(negedge i_clock);
        // Back-to-back random accesses, small values so matches are frequent
        for (int i = 0; i < 400; i++) begin
            cfg.rng_src = 2'($urandom_range(0, 3));
            cfg.rng_mode = (i % 3 == 2) ? WPT_RNG_OUT : wpt_rng_mode_t'(i % 3);
            cfg.eq_src = 2'($urandom_range(0, 3));
            cfg.eq_mode = wpt_eq_mode_t'(i % 8);
            {cfg.eq_out_mode, cfg.use_and, cfg.brk_out_en} = 3'($urandom_range(0, 7));
            {lo, hi, v0, v1, v2} = {r4(), r4() + 16'h8, r4(), r4() + 16'h8, r4()};
            {ip, addr, data, tid} = {r4(), r4(), r4(), r4()};
            {fetch, rd, wr} = 3'h1 << $urandom_range(0, 2);
            q.push_back({1'b0, exp_hit() & cfg.brk_out_en});
            @(negedge i_clock);
        end
        // Halt, suspension, monitor level and stepping
        {fetch, rd, wr} = 3'h4;
        cfg = '0;
        {cfg.rng_mode, cfg.debug_en, cfg.brk_out_en} = {WPT_RNG_IN, 2'h3};
        {lo, hi, ip, susp, irq_req, ilev, mlev} = {16'hA, 16'h14, 16'hF, 2'h3, 4'h5, 4'h3};
        q.push_back(2'h3);
        @(negedge i_clock);
        check({brk, halt}, 2'h3);
        @(negedge i_clock);
        check({brk, psus, irqa}, 3'h2);
        check(trig, 1'b0);
        susp = 0;
        repeat (2) @(negedge i_clock);
        fetch = 0;
        check({trig, psus, irqa}, 3'h1);
        mlev = 4'h7;
        repeat (2) @(negedge i_clock);
        check(irqa, 1'b0);
        {smask, step} = 2'h3;
        @(negedge i_clock);
        step = 0;
        @(negedge i_clock);
        check({halt, irqa}, 2'h0);
        {fetch, ip} = {1'b1, 16'h64};
        @(negedge i_clock);
        fetch = 0;
        @(negedge i_clock);
        check(halt, 1'b1);
        resume = 1;
        @(negedge i_clock);
        resume = 0;
        @(negedge i_clock);
        check(halt, 1'b0);
        // Clock enable low: an in-range fetch must leave halt, break and trigger low
        {en, fetch, ip} = {1'b0, 1'b1, 16'hF};
        repeat (2) @(negedge i_clock);
        check({halt, brk, trig}, 3'h0);
        {en, fetch} = 2'h2;
        @(negedge i_clock);
        // Shadow copy follows writes while running
        cfg = '0;
        for (int i = 0; i < 8; i++) begin
            {wr, addr, data} = {1'b1, 16'(i * 37), 16'($urandom)};
            mem[i] = data;
            @(negedge i_clock);
        end
        wr = 0;
        for (int i = 0; i < 8; i++) begin
            sraddr = 8'(i * 37);
            @(negedge i_clock);
            check(srd, mem[i]);
        end
        close_out();
    end
endmodule
